// *** verilog/ofd_decoder.sv ***
// operand field decoder: collects operand bytes and forms operands
// Summary of operation
// - size bit 1 means word, 0 byte
// - sign bit 1 sign-extends the immediate byte when size bit is 1
// - all eight register codes are valid
// - register code plus size names the register
// - forms 00-10 with eight locators address memory
// - locator picks base sum, form picks displacement
// - 16-bit displacement arrives low byte first
// - 16-bit immediate arrives low byte first
// - direct address arrives low byte first
// - far target: offset then segment, low first
// - short target adds signed byte to end pointer
// - near target adds 16-bit displacement to pointer
// - stack-release count is 16 bits, low first
// - block operands use source and dest index
// - translation indexes a 256-byte table
// - segment select field maps to four segments
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder
	import ofd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// decode request
	input wire logic start_i,
	input var ofd_kind_type kind_i,
	input wire logic size_i,
	input wire logic sext_i,
	input wire logic imm_en_i,
	input wire logic [1:0] seg_field_i,
	output logic busy_o,
	// instruction byte stream from the fetch queue
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	output logic byte_ready_o,
	// register state from the datapath
	input wire logic [7:0][15:0] gpr_i,
	input wire logic [15:0] next_ip_i,
	// decoded results
	output logic done_o,
	output logic is_reg_o,
	output var ofd_reg_type reg_id_o,
	output logic [15:0] reg_value_o,
	output logic [15:0] ea_o,
	output logic [15:0] imm_o,
	output logic [15:0] tgt_ip_o,
	output logic [15:0] tgt_seg_o,
	output logic [15:0] src_addr_o,
	output logic [15:0] dst_addr_o,
	output var ofd_seg_type seg_sel_o
);
	// -----------------------------------------------------------------
	// types and helpers
	// -----------------------------------------------------------------
	// sequence of byte slots
	typedef enum logic [3:0] {
		ST_IDLE, ST_MODE, ST_DISP_LO, ST_DISP_HI, ST_IMM_LO,
		ST_IMM_HI, ST_SEG_LO, ST_SEG_HI, ST_FINISH
	} ofd_state_type;

	// all state of the decoder
	typedef struct packed {
		ofd_state_type st; // byte slot
		ofd_kind_type kind; // latched request kind
		logic size; // word when set
		logic sext; // sign-extend immediate byte
		logic imm_en; // immediate follows addressing bytes
		logic disp_two; // displacement has two bytes
		logic [1:0] mode; // addressing form
		logic [2:0] loc; // locator or register code
		logic [15:0] disp; // displacement or direct address
		logic [15:0] imm; // immediate or offset
		logic [15:0] seg; // far segment word
		ofd_seg_type seg_sel; // segment select
		logic done; // result pulse
		logic is_reg; // operand is a register
		ofd_reg_type reg_id; // selected register
		logic [15:0] reg_value; // its value
		logic [15:0] ea; // effective address
		logic [15:0] tgt_ip; // transfer target offset
		logic [15:0] tgt_seg; // transfer target segment
		logic [15:0] src_addr; // block source address
		logic [15:0] dst_addr; // block destination address
	} ofd_regs_type;

	// sign-extend a byte to a word
	function automatic logic [15:0] sext8(input logic [7:0] b);
		return {{BYTE_W{b[7]}}, b};
	endfunction

	// zero-extend a byte to a word
	function automatic logic [15:0] zext8(input logic [7:0] b);
		return {ZERO_BYTE, b};
	endfunction

	// value of the register named by code and size
	function automatic logic [15:0] reg_val(
		input logic [7:0][15:0] g,
		input logic w,
		input logic [2:0] code
	);
		logic [15:0] word;
		word = g[{1'b0, code[1:0]}];
		if (w) begin
			return g[code];
		end else if (code[2]) begin
			return zext8(word[15:8]); // high byte of the pair
		end else begin
			return zext8(word[7:0]); // low byte of the pair
		end
	endfunction

	// does the immediate slot take two bytes
	function automatic logic imm_wide(input ofd_regs_type s);
		unique case (s.kind)
			K_NEAR_REL, K_FAR, K_STACK_REL: return 1'b1;
			K_SHORT_REL: return 1'b0;
			default: return s.size && !s.sext;
		endcase
	endfunction

	// does an immediate follow the addressing bytes
	function automatic logic imm_en_next(input ofd_regs_type s);
		return s.imm_en;
	endfunction

	// -----------------------------------------------------------------
	// state and address adder
	// -----------------------------------------------------------------
	ofd_regs_type r_r; // registered state
	ofd_regs_type r_nxt; // next state
	ofd_ea_if ea_if (); // link to the adder
	logic take; // byte accepted this cycle

	// adder terms come from latched fields and live registers
	assign ea_if.mode = r_r.mode;
	assign ea_if.loc = r_r.loc;
	assign ea_if.disp = r_r.disp;
	assign ea_if.base_gp = gpr_i[IDX_BASE_GP];
	assign ea_if.frame = gpr_i[IDX_FRAME];
	assign ea_if.src = gpr_i[IDX_SRC];
	assign ea_if.dst = gpr_i[IDX_DST];

	// effective-address adder
	ofd_ea_calc u_ea (
		.ea_if(ea_if.calc)
	);

	// a byte is wanted in every slot between idle and finish
	assign byte_ready_o = (r_r.st != ST_IDLE) && (r_r.st != ST_FINISH);
	assign take = byte_ready_o && byte_valid_i;
	assign busy_o = (r_r.st != ST_IDLE);

	// -----------------------------------------------------------------
	// next-state logic
	// -----------------------------------------------------------------
	// walks the byte slots and forms results at finish
	always_comb begin
		r_nxt = r_r;
		r_nxt.done = 1'b0;
		unique case (r_r.st)
			ST_IDLE: begin
				if (start_i) begin
					// latch the request; clear operand fields
					r_nxt.kind = kind_i;
					r_nxt.size = size_i;
					r_nxt.sext = sext_i;
					r_nxt.imm_en = imm_en_i;
					r_nxt.seg_sel = ofd_seg_type'(seg_field_i);
					r_nxt.disp = ZERO_WORD;
					r_nxt.imm = ZERO_WORD;
					r_nxt.seg = ZERO_WORD;
					r_nxt.is_reg = 1'b0;
					r_nxt.mode = MODE_NO_DISP;
					r_nxt.loc = LOC_FB;
					r_nxt.disp_two = 1'b1;
					unique case (kind_i)
						K_MEMREG: r_nxt.st = ST_MODE;
						K_DIRECT: r_nxt.st = ST_DISP_LO;
						K_BLOCK, K_XLAT: r_nxt.st = ST_FINISH;
						default: r_nxt.st = ST_IMM_LO;
					endcase
				end
			end
			ST_MODE: begin
				if (take) begin
					r_nxt.mode = byte_i[MODE_HI:MODE_LO];
					r_nxt.loc = byte_i[LOC_HI:LOC_LO];
					r_nxt.disp_two = 1'b0;
					if (byte_i[MODE_HI:MODE_LO] == MODE_REG) begin
						r_nxt.is_reg = 1'b1; // register operand
						r_nxt.st = imm_en_next(r_r) ? ST_IMM_LO : ST_FINISH;
					end else if (byte_i[MODE_HI:MODE_LO] == MODE_SHORT_OFFSET) begin
						r_nxt.st = ST_DISP_LO;
					end else if (byte_i[MODE_HI:MODE_LO] == MODE_DISP16 ||
						byte_i[LOC_HI:LOC_LO] == LOC_FB) begin
						r_nxt.disp_two = 1'b1;
						r_nxt.st = ST_DISP_LO;
					end else begin
						r_nxt.st = imm_en_next(r_r) ? ST_IMM_LO : ST_FINISH;
					end
				end
			end
			ST_DISP_LO: begin
				if (take) begin
					// one-byte displacement is signed
					if (r_r.disp_two) begin
						r_nxt.disp = zext8(byte_i);
						r_nxt.st = ST_DISP_HI;
					end else begin
						r_nxt.disp = sext8(byte_i);
						r_nxt.st = imm_en_next(r_r) ? ST_IMM_LO : ST_FINISH;
					end
				end
			end
			ST_DISP_HI: begin
				if (take) begin
					r_nxt.disp[15:8] = byte_i;
					r_nxt.st = imm_en_next(r_r) ? ST_IMM_LO : ST_FINISH;
				end
			end
			ST_IMM_LO: begin
				if (take) begin
					if (imm_wide(r_r)) begin
						r_nxt.imm = zext8(byte_i);
						r_nxt.st = ST_IMM_HI;
					end else if (r_r.kind == K_SHORT_REL) begin
						r_nxt.imm = sext8(byte_i);
						r_nxt.st = ST_FINISH;
					end else if (r_r.size && r_r.sext) begin
						r_nxt.imm = sext8(byte_i);
						r_nxt.st = ST_FINISH;
					end else begin
						r_nxt.imm = zext8(byte_i);
						r_nxt.st = ST_FINISH;
					end
				end
			end
			ST_IMM_HI: begin
				if (take) begin
					r_nxt.imm[15:8] = byte_i;
					r_nxt.st = (r_r.kind == K_FAR) ? ST_SEG_LO : ST_FINISH;
				end
			end
			ST_SEG_LO: begin
				if (take) begin
					r_nxt.seg = zext8(byte_i);
					r_nxt.st = ST_SEG_HI;
				end
			end
			ST_SEG_HI: begin
				if (take) begin
					r_nxt.seg[15:8] = byte_i;
					r_nxt.st = ST_FINISH;
				end
			end
			ST_FINISH: begin
				// publish results for one pulse
				r_nxt.done = 1'b1;
				r_nxt.st = ST_IDLE;
				r_nxt.reg_id = ofd_reg_type'({r_r.size, r_r.loc});
				r_nxt.reg_value = reg_val(gpr_i, r_r.size, r_r.loc);
				r_nxt.ea = ea_if.ea;
				r_nxt.tgt_ip = r_r.imm;
				r_nxt.tgt_seg = r_r.seg;
				r_nxt.src_addr = gpr_i[IDX_SRC];
				r_nxt.dst_addr = gpr_i[IDX_DST];
				unique case (r_r.kind)
					K_SHORT_REL: r_nxt.tgt_ip = next_ip_i + r_r.imm;
					K_NEAR_REL: r_nxt.tgt_ip = next_ip_i + r_r.imm;
					K_FAR: r_nxt.tgt_seg = r_r.seg;
					K_BLOCK: r_nxt.ea = gpr_i[IDX_SRC];
					K_XLAT: begin
						// byte-wide index keeps it inside 256 entries
						r_nxt.ea = gpr_i[IDX_BASE_GP] + zext8(gpr_i[IDX_ACCUM][7:0]);
					end
					default: r_nxt.tgt_ip = r_r.imm;
				endcase
			end
		endcase
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	// all state resets to idle with cleared results
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign done_o = r_r.done;
	assign is_reg_o = r_r.is_reg;
	assign reg_id_o = r_r.reg_id;
	assign reg_value_o = r_r.reg_value;
	assign ea_o = r_r.ea;
	assign imm_o = r_r.imm;
	assign tgt_ip_o = r_r.tgt_ip;
	assign tgt_seg_o = r_r.tgt_seg;
	assign src_addr_o = r_r.src_addr;
	assign dst_addr_o = r_r.dst_addr;
	assign seg_sel_o = r_r.seg_sel;
endmodule
`default_nettype wire

// *** verilog/ofd_pkg.sv ***
// package of constants and types for the operand field decoder
`default_nettype none
package ofd_pkg;
	// -----------------------------------------------------------------
	// field layout of the addressing byte
	// -----------------------------------------------------------------
	localparam int MODE_HI = 7; // addressing-form field msb
	localparam int MODE_LO = 6; // addressing-form field lsb
	localparam int LOC_HI = 2; // operand-locator field msb
	localparam int LOC_LO = 0; // operand-locator field lsb
	localparam int BYTE_W = 8; // instruction byte width
	localparam int WORD_W = 16; // operand and address width
	// -----------------------------------------------------------------
	// addressing-form and locator codes
	// -----------------------------------------------------------------
	localparam logic [1:0] MODE_NO_DISP = 2'h0; // no displacement
	localparam logic [1:0] MODE_SHORT_OFFSET = 2'h1; // 8-bit displacement
	localparam logic [1:0] MODE_DISP16 = 2'h2; // 16-bit displacement
	localparam logic [1:0] MODE_REG = 2'h3; // register operand
	localparam logic [2:0] LOC_BG_SRC = 3'h0; // base_gp + source
	localparam logic [2:0] LOC_BG_DST = 3'h1; // base_gp + dest
	localparam logic [2:0] LOC_FB_SRC = 3'h2; // frame + source
	localparam logic [2:0] LOC_FB_DST = 3'h3; // frame + dest
	localparam logic [2:0] LOC_SRC = 3'h4; // source only
	localparam logic [2:0] LOC_DST = 3'h5; // dest only
	localparam logic [2:0] LOC_FB = 3'h6; // frame, or direct
	localparam logic [2:0] LOC_BG = 3'h7; // base_gp only
	// -----------------------------------------------------------------
	// word register file indices (gpr_i slots)
	// -----------------------------------------------------------------
	localparam logic [2:0] IDX_ACCUM = 3'h0; // accum_full
	localparam logic [2:0] IDX_BASE_GP = 3'h3; // base_gp_full
	localparam logic [2:0] IDX_FRAME = 3'h5; // frame_base_ptr
	localparam logic [2:0] IDX_SRC = 3'h6; // source_index
	localparam logic [2:0] IDX_DST = 3'h7; // dest_index
	localparam logic [7:0] ZERO_BYTE = 8'h00; // zero fill
	localparam logic [15:0] ZERO_WORD = 16'h0000; // reset value
	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	// what the current instruction asks to be decoded
	typedef enum logic [3:0] {
		K_MEMREG, // addressing byte, disp, optional immediate
		K_IMM, // immediate only
		K_DIRECT, // 16-bit direct address
		K_SHORT_REL, // signed short_offset
		K_NEAR_REL, // 16-bit relative displacement
		K_FAR, // offset then segment
		K_STACK_REL, // stack-release byte count
		K_BLOCK, // block source and destination
		K_XLAT // table translation
	} ofd_kind_type;
	// selected general register, index is {size bit, code}
	typedef enum logic [3:0] {
		R_ACCUM_LO, R_COUNT_LO, R_DATA_LO, R_BASE_GP_LO,
		R_ACCUM_HI, R_COUNT_HI, R_DATA_HI, R_BASE_GP_HI,
		R_ACCUM_FULL, R_COUNT_FULL, R_DATA_FULL, R_BASE_GP_FULL,
		R_STACK_TOP_PTR, R_FRAME_BASE_PTR, R_SOURCE_INDEX, R_DEST_INDEX
	} ofd_reg_type;
	// segment register named by the two-bit select field
	typedef enum logic [1:0] {
		SEG_DATA_ONE, SEG_PROGRAM, SEG_STACK, SEG_DATA_ZERO
	} ofd_seg_type;
endpackage
`default_nettype wire

// *** verilog/ofd_ea_if.sv ***
// interface carrying an effective-address request and its result
`timescale 1ns/1ps
`default_nettype none
interface ofd_ea_if;
	logic [1:0] mode; // addressing form
	logic [2:0] loc; // operand locator
	logic [15:0] disp; // displacement or direct address
	logic [15:0] base_gp; // base_gp_full value
	logic [15:0] frame; // frame_base_ptr value
	logic [15:0] src; // source_index value
	logic [15:0] dst; // dest_index value
	logic [15:0] ea; // resulting address
	// adder side
	modport calc (input mode, loc, disp, base_gp, frame, src, dst, output ea);
	// decoder side
	modport user (output mode, loc, disp, base_gp, frame, src, dst, input ea);
endinterface
`default_nettype wire

// *** verilog/ofd_ea_calc.sv ***
// effective-address adder for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_ea_calc
	import ofd_pkg::*;
(
	// request and result
	ofd_ea_if.calc ea_if
);
	// -----------------------------------------------------------------
	// base selection and sum
	// -----------------------------------------------------------------
	logic [15:0] base_sel; // first term
	logic [15:0] index_sel; // second term
	logic [15:0] disp_sel; // third term

	// pick the terms for the locator code
	always_comb begin
		base_sel = ZERO_WORD;
		index_sel = ZERO_WORD;
		unique case (ea_if.loc)
			LOC_BG_SRC: begin
				base_sel = ea_if.base_gp;
				index_sel = ea_if.src;
			end
			LOC_BG_DST: begin
				base_sel = ea_if.base_gp;
				index_sel = ea_if.dst;
			end
			LOC_FB_SRC: begin
				base_sel = ea_if.frame;
				index_sel = ea_if.src;
			end
			LOC_FB_DST: begin
				base_sel = ea_if.frame;
				index_sel = ea_if.dst;
			end
			LOC_SRC: base_sel = ea_if.src;
			LOC_DST: base_sel = ea_if.dst;
			LOC_FB: begin
				// direct address takes frame's place at form 00
				if (ea_if.mode == MODE_NO_DISP) begin
					base_sel = ZERO_WORD;
				end else begin
					base_sel = ea_if.frame;
				end
			end
			LOC_BG: base_sel = ea_if.base_gp;
		endcase
	end

	// displacement joins unless form is 00 (direct counts as disp)
	always_comb begin
		disp_sel = ZERO_WORD;
		if (ea_if.mode != MODE_NO_DISP || ea_if.loc == LOC_FB) begin
			disp_sel = ea_if.disp;
		end
	end

	// 16-bit sum, carry out of bit 15 is dropped
	assign ea_if.ea = base_sel + index_sel + disp_sel;
endmodule
`default_nettype wire

// *** verification/ofd_decoder_monitor.sv ***
// checker for the operand field decoder ports
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder_monitor
	import ofd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// request side
	input wire logic start_i,
	input var ofd_kind_type kind_i,
	input wire logic [1:0] seg_field_i,
	input wire logic busy_o,
	input wire logic byte_ready_o,
	// datapath side
	input wire logic [7:0][15:0] gpr_i,
	input wire logic [15:0] next_ip_i,
	// results
	input wire logic done_o,
	input wire logic [15:0] ea_o,
	input wire logic [15:0] imm_o,
	input wire logic [15:0] tgt_ip_o,
	input wire logic [15:0] dst_addr_o,
	input var ofd_seg_type seg_sel_o
);
	// ---------------------------------------------
	// helper state
	// ---------------------------------------------
	ofd_kind_type kind_r; // kind of the request in flight
	logic [7:0][15:0] gpr_r; // registers as seen at the finish edge
	logic [15:0] ip_r; // end pointer as seen at the finish edge
	// remember the kind of each accepted request
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			kind_r <= K_MEMREG;
		end else if (start_i && !busy_o) begin
			kind_r <= kind_i;
		end
	end
	// one-edge copy, since the bench may move inputs in the done cycle
	always_ff @(posedge clk_sys_i) begin
		gpr_r <= gpr_i;
		ip_r <= next_ip_i;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	busy_after_start_a:
		assert property (start_i && !busy_o |=> busy_o) else $error("busy did not follow start");
	done_bound_a:
		assert property (start_i && !busy_o |-> ##[2:100] done_o) else $error("no completion in time");
	done_pulse_a:
		assert property (done_o |=> !done_o) else $error("done longer than one cycle");
	done_idle_a:
		assert property (done_o |-> !busy_o && !byte_ready_o) else $error("busy or ready in done cycle");
	ready_busy_a:
		assert property (byte_ready_o |-> busy_o) else $error("byte ready while idle");
	seg_map_a:
		assert property (start_i && !busy_o |=> seg_sel_o == ofd_seg_type'($past(seg_field_i)))
		else $error("segment select mismatch");
	block_addr_a:
		assert property (done_o && kind_r == K_BLOCK |-> ea_o == gpr_r[6] && dst_addr_o == gpr_r[7])
		else $error("block addresses wrong");
	xlat_addr_a:
		assert property (done_o && kind_r == K_XLAT |-> ea_o == 16'(gpr_r[3] + {8'h00, gpr_r[0][7:0]}))
		else $error("translation address wrong");
	short_target_a:
		assert property (done_o && kind_r == K_SHORT_REL |-> imm_o[15:8] == {8{imm_o[7]}}
			&& tgt_ip_o == 16'(ip_r + imm_o)) else $error("short target wrong");
endmodule
bind ofd_decoder ofd_decoder_monitor ofd_decoder_monitor_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.start_i(start_i), .kind_i(kind_i), .seg_field_i(seg_field_i), .busy_o(busy_o),
	.byte_ready_o(byte_ready_o), .gpr_i(gpr_i), .next_ip_i(next_ip_i), .done_o(done_o), .ea_o(ea_o),
	.imm_o(imm_o), .tgt_ip_o(tgt_ip_o), .dst_addr_o(dst_addr_o), .seg_sel_o(seg_sel_o));
`default_nettype wire

// *** verification/ofd_fetch_model.sv ***
// fetch queue model feeding instruction bytes
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// bench control
	input wire logic stall_i,
	// byte handshake
	input wire logic byte_ready_i,
	output logic byte_valid_o,
	output logic [7:0] byte_o
);
	logic [7:0] q[$]; // bytes still to offer
	// add a byte at the tail
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask
	// drop anything left over
	task automatic flush();
		q.delete();
	endtask
	// one process drives the line: take on a rising edge, offer on the falling edge
	initial begin
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
		forever begin
			// hold the offer until it is taken
			@(posedge clk_sys_i);
			if (byte_valid_o && byte_ready_i) begin
				void'(q.pop_front());
				byte_valid_o <= 1'b0;
			end
			// offer a byte, or scramble the idle line so stale data never matches
			@(negedge clk_sys_i);
			if (!byte_valid_o) begin
				if (q.size() != 0 && !stall_i && reset_n_i) begin
					byte_valid_o <= 1'b1;
					byte_o <= q[0];
				end else begin
					byte_o <= ~byte_o;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ofd_pkg::*;
();
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic clk_sys_i, reset_n_i, start_i, size_i, sext_i, imm_en_i, dbl;
	logic stall = 1'b0; // far side holds back
	logic byte_valid_i, busy_o, byte_ready_o, done_o, is_reg_o;
	logic [7:0] byte_i;
	logic [1:0] seg_field_i, sg;
	logic [7:0][15:0] gpr_i;
	logic [15:0] next_ip_i, reg_value_o, ea_o, imm_o, tgt_ip_o, tgt_seg_o, src_addr_o, dst_addr_o;
	ofd_kind_type kind_i;
	ofd_reg_type reg_id_o;
	ofd_seg_type seg_sel_o;
	logic [31:0] seed, st = 32'he24b0047; // xorshift states
	logic [7:0] bq[$]; // bytes of the next instruction
	int mismatches, cmp_count;
	ofd_decoder ofd_decoder_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start_i),
		.kind_i(kind_i), .size_i(size_i), .sext_i(sext_i), .imm_en_i(imm_en_i), .seg_field_i(seg_field_i),
		.busy_o(busy_o), .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
		.gpr_i(gpr_i), .next_ip_i(next_ip_i), .done_o(done_o), .is_reg_o(is_reg_o), .reg_id_o(reg_id_o),
		.reg_value_o(reg_value_o), .ea_o(ea_o), .imm_o(imm_o), .tgt_ip_o(tgt_ip_o), .tgt_seg_o(tgt_seg_o),
		.src_addr_o(src_addr_o), .dst_addr_o(dst_addr_o), .seg_sel_o(seg_sel_o));
	ofd_fetch_model ofd_fetch_model_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .stall_i(stall),
		.byte_ready_i(byte_ready_o), .byte_valid_o(byte_valid_i), .byte_o(byte_i));
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [15:0] r16();
		seed = xs(seed);
		return seed[15:0];
	endfunction
	function automatic logic [15:0] sx8(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction
	// expected address of a memory form, wrapping at 16 bits
	function automatic logic [15:0] ea_exp(input logic [1:0] m, input logic [2:0] l, input logic [15:0] d);
		logic [15:0] bs;
		case (l)
			3'h0: bs = gpr_i[3] + gpr_i[6];
			3'h1: bs = gpr_i[3] + gpr_i[7];
			3'h2: bs = gpr_i[5] + gpr_i[6];
			3'h3: bs = gpr_i[5] + gpr_i[7];
			3'h4: bs = gpr_i[6];
			3'h5: bs = gpr_i[7];
			3'h6: bs = gpr_i[5];
			default: bs = gpr_i[3];
		endcase
		if (m == 2'h0 && l == 3'h6) return d;
		return bs + ((m == 2'h0) ? 16'h0000 : d);
	endfunction
	// expected register contents, bytes zero-extended
	function automatic logic [15:0] rv_exp(input logic w, input logic [2:0] c);
		if (w) return gpr_i[c];
		return c[2] ? {8'h00, gpr_i[c[1:0]][15:8]} : {8'h00, gpr_i[c[1:0]][7:0]};
	endfunction
	// segment named by each select code
	function automatic ofd_seg_type seg_exp(input logic [1:0] c);
		case (c)
			2'h0: return SEG_DATA_ONE;
			2'h1: return SEG_PROGRAM;
			2'h2: return SEG_STACK;
			default: return SEG_DATA_ZERO;
		endcase
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one decode: load bytes, pulse start, wait for done under a bound
	task automatic run(input ofd_kind_type k, input logic sz, input logic sx, input logic ie);
		int n;
		@(negedge clk_sys_i);
		ofd_fetch_model_i.flush();
		foreach (bq[j]) ofd_fetch_model_i.push(bq[j]);
		for (int j = 0; j < 8; j++) gpr_i[j] = r16();
		next_ip_i = r16();
		kind_i = k;
		size_i = sz;
		sext_i = sx;
		imm_en_i = ie;
		seg_field_i = sg;
		start_i = 1'b1;
		@(negedge clk_sys_i);
		start_i = dbl;
		// poll on falling edges so a done pulse right after finish is seen
		n = 0;
		while (done_o !== 1'b1 && n < 100) begin
			@(negedge clk_sys_i);
			start_i = 1'b0;
			n++;
		end
		if (n >= 100) chk(16'h0000, 16'h0001);
	endtask
	// ---------------------------------------------
	// clock, stall pattern, watchdog
	// ---------------------------------------------
	always #5 clk_sys_i = ~clk_sys_i;
	// far side stalls about one cycle in four
	always @(negedge clk_sys_i) begin
		st <= xs(st);
		stall <= (st[1:0] == 2'h0);
	end
	// fifty-five decodes of under twenty cycles each fit well inside this
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	// ---------------------------------------------
	// tests
	// ---------------------------------------------
	initial begin
		logic [15:0] d, e;
		logic [1:0] m;
		logic [2:0] l;
		clk_sys_i = 1'b0;
		reset_n_i = 1'b0;
		{start_i, size_i, sext_i, imm_en_i, dbl, sg} = '0;
		seg_field_i = 2'h0;
		kind_i = K_MEMREG;
		gpr_i = '0;
		next_ip_i = 16'h0000;
		seed = 32'he24b0047;
		mismatches = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		reset_n_i = 1'b1;
		chk(busy_o, 16'h0000);
		// register operands, all codes at both widths
		for (int i = 0; i < 16; i++) begin
			bq = {8'hc0 | {5'h00, i[2:0]}};
			run(K_MEMREG, i[3], 1'b0, 1'b0);
			chk(is_reg_o, 16'h0001);
			chk(reg_id_o, i[3:0]);
			chk(reg_value_o, rv_exp(i[3], i[2:0]));
		end
		$display("register operands done");
		// all 24 memory forms with random displacements
		for (int i = 0; i < 24; i++) begin
			d = r16();
			m = 2'(i / 8);
			l = 3'(i % 8);
			bq = {{m, 3'h5, l}};
			if (m != 2'h0 || l == 3'h6) bq.push_back(d[7:0]);
			if (m == 2'h2 || (m == 2'h0 && l == 3'h6)) bq.push_back(d[15:8]);
			if (m == 2'h1) d = sx8(d[7:0]);
			run(K_MEMREG, 1'b1, 1'b0, 1'b0);
			chk(is_reg_o, 16'h0000);
			chk(ea_o, ea_exp(m, l, d));
		end
		$display("memory forms done");
		// immediates for every size and sign-extension setting
		for (int i = 0; i < 4; i++) begin
			d = r16() | 16'h0080;
			bq = {d[7:0]};
			if (i == 2) bq.push_back(d[15:8]);
			run(K_IMM, i[1], i[0], 1'b0);
			chk(imm_o, (i == 2) ? d : (i == 3) ? sx8(d[7:0]) : {8'h00, d[7:0]});
		end
		// memory operand followed by a word immediate
		d = r16();
		e = r16();
		bq = {8'h82, d[7:0], d[15:8], e[7:0], e[15:8]};
		run(K_MEMREG, 1'b1, 1'b0, 1'b1);
		chk(ea_o, ea_exp(2'h2, 3'h2, d));
		chk(imm_o, e);
		$display("immediates done");
		// direct address and far target
		bq = {d[7:0], d[15:8]};
		run(K_DIRECT, 1'b1, 1'b0, 1'b0);
		chk(ea_o, d);
		bq = {e[7:0], e[15:8], d[7:0], d[15:8]};
		run(K_FAR, 1'b1, 1'b0, 1'b0);
		chk(tgt_ip_o, e);
		chk(tgt_seg_o, d);
		// short targets at both ends of the reach
		for (int i = 0; i < 2; i++) begin
			bq = {i[0] ? 8'h7f : 8'h80};
			run(K_SHORT_REL, 1'b0, 1'b0, 1'b0);
			chk(tgt_ip_o, next_ip_i + sx8(bq[0]));
		end
		bq = {d[7:0], d[15:8]};
		run(K_NEAR_REL, 1'b1, 1'b0, 1'b0);
		chk(tgt_ip_o, next_ip_i + d);
		bq = {8'hff, 8'hfe};
		run(K_STACK_REL, 1'b1, 1'b0, 1'b0);
		chk(imm_o, 16'hfeff);
		$display("transfer targets done");
		// block and translation, every segment code, some with a start while busy
		for (int i = 0; i < 4; i++) begin
			sg = i[1:0];
			dbl = i[0];
			bq = {};
			run(i[1] ? K_XLAT : K_BLOCK, 1'b0, 1'b0, 1'b0);
			chk(seg_sel_o, seg_exp(i[1:0]));
			if (i[1]) chk(ea_o, gpr_i[3] + {8'h00, gpr_i[0][7:0]});
			else chk(ea_o, gpr_i[6]);
			if (!i[1]) chk(dst_addr_o, gpr_i[7]);
			chk(src_addr_o, gpr_i[6]);
			@(posedge clk_sys_i);
			#1;
			chk(busy_o, 16'h0000);
		end
		dbl = 1'b0;
		$display("block, translation and segments done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
